// ### shared/i2c3m_pkg.sv
// Constants, types and the rate table of the three-byte I2C master
package i2c3m_pkg;
  // Register map, byte addresses on the AXI4-Lite bus
  localparam int unsigned AXI_AW    = 8;
  localparam logic [7:0]  XFER_OFS  = 8'h8C;
  localparam logic [7:0]  STAT_OFS  = 8'h90;
  localparam logic [7:0]  IRQEN_OFS = 8'h84;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Field positions
  localparam int unsigned BUSY_BIT  = 0;
  localparam int unsigned ERR_BIT   = 1;
  localparam int unsigned FLAG_LO   = 2;
  localparam int unsigned FLAG_HI   = 6;
  localparam int unsigned ABORT_BIT = 7;
  localparam int unsigned RATE_LO   = 8;
  localparam int unsigned RATE_HI   = 10;
  localparam int unsigned BYTE_TOP  = 31;
  localparam int unsigned ATTR_TOP  = 7;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned ATTR_W    = 2;
  localparam logic [31:0] XFER_WMASK = 32'hFFFF_FFFC;

  // Error flag indices inside the five-bit flag field
  localparam int unsigned NFLAG = 5;
  localparam int unsigned F_AL  = 0;
  localparam int unsigned F_DR  = 1;
  localparam int unsigned F_DT  = 2;
  localparam int unsigned F_AP  = 3;
  localparam int unsigned F_SP  = 4;

  // Reset values
  localparam logic [31:0] XFER_RST = 32'h0000_0000;
  localparam logic [2:0]  RATE_RST = 3'h0;

  // Bit sequencing
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE  = 2'h1;
  localparam logic [1:0] PH_HIGH  = 2'h2;
  localparam logic [1:0] PH_FALL  = 2'h3;
  localparam logic [3:0] LAST_DATA = 4'h7;
  localparam logic [3:0] ACK_BIT   = 4'h8;
  localparam logic [1:0] SLOT_FIRST = 2'h0;
  localparam logic [1:0] SLOT_DONE  = 2'h3;
  localparam int unsigned QUARTERS  = 4;

  typedef enum logic [1:0] {
    A_NOP   = 2'h0,
    A_STOP  = 2'h1,
    A_TRANSFER_AND_CONTINUE  = 2'h2,
    A_START = 2'h3
  } i2c3m_attr_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SLOT  = 3'h1,
    ST_START = 3'h3,
    ST_BIT   = 3'h2,
    ST_STOP  = 3'h6,
    ST_END   = 3'h7
  } i2c3m_state_t;

  // Bit period in system clocks for each rate code
  function automatic logic [12:0] i2c3m_rate_div(input logic [2:0] code);
    case (code)
      3'h5:    return 13'h1900;
      3'h1:    return 13'h0C80;
      3'h4:    return 13'h01E0;
      3'h6:    return 13'h0140;
      3'h7:    return 13'h00F0;
      3'h0:    return 13'h0078;
      3'h2:    return 13'h0050;
      default: return 13'h003C;
    endcase
  endfunction
endpackage

// ### hdl/i2c3m_sync.sv
// Two-stage synchronisers for the bus line inputs
`timescale 1ns/1ps
module i2c3m_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // Idle bus lines float high, so both stages reset high
  for (genvar i = 0; i < WIDTH; i++) begin : g_line
    logic meta_r;
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        meta_r      <= 1'b1;
        sync_out[i] <= 1'b1;
      end else if (ce) begin
        meta_r      <= async_in[i];
        sync_out[i] <= meta_r;
      end
    end
  end
endmodule

// ### hdl/i2c3m_core.sv
// Register-driven three-byte I2C master with AXI4-Lite register port
`timescale 1ns/1ps
// Operation
// (RL1) Rate code picks bit period: clock over 6400..60 by table.
// (RL2) Slaves may hold SCL low; the bit timer waits.
// (RL3) Writing abort ends the operation and clears busy.
// (RL4) Separate sticky flags: start/stop, address, send, receive, arbitration.
// (RL5) Summary error stays set until every flag is cleared.
// (RL6) Software clears all flags before a new command, twice after abort.
// (RL7) Transfer word: three bytes high, three two-bit attributes below.
// (RL8) Attribute 11 start, 10 continue, 01 stop, 00 skip.
// (RL9) Start byte: start or restart, address and direction, then acknowledge.
// (RL10) Continue byte: eight bits MSB first, acknowledge, keep the bus.
// (RL11) Stop byte: eight bits, acknowledge or not, then stop condition.
// (RL12) Hardware makes acknowledges; not-acknowledge after last read byte.
// (RL13) Read bytes land in their own slot of the transfer word.
// (RL14) Busy high during cycle; cleared at end only without error.
// (RL15) End of cycle pulses the interrupt request when enabled.
// (RL16) Transfer write while busy sets the summary error.
// (RL17) Clean three-slot run leaves the summary error low.
// (RL18) On error summary sets and busy stays until software clears.
// (RL19) Software may chain sequences and check the error once.
// (RL20) Transfer word mirrors summary error at bit 1, busy at 0.
// (RL21) Slots run in order: upper, middle, lower.
// (RL22) Lost arbitration releases the lines at once.
// (RL23) Bus clock generator covers the supported rate span.
// (RL24) Lines only pulled low; SDA sampled while SCL high.
module i2c3m_core
  import i2c3m_pkg::*;
#(
  parameter int unsigned QW = 11
) (
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic                        ce,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [i2c3m_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic      [1:0]                  s_axi_bresp,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [i2c3m_pkg::AXI_AW-1:0] s_axi_araddr,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  input  wire logic                        scl_i,
  output logic                             scl_o,
  output logic                             scl_oe,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe,
  output logic                             cycle_irq
);
  import i2c3m_pkg::*;

  logic              aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [AXI_AW-1:0] aw_addr_r;
  logic [31:0]       w_data_r, rdata_r, xfer_r;
  logic [3:0]        w_strb_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [2:0]        rate_r;
  logic [NFLAG-1:0]  flags_r;
  logic              ovr_r, busy_r, irq_en_r, irq_r;
  i2c3m_state_t      st_r;
  logic [1:0]        slot_r, ph_r;
  logic [3:0]        bit_r;
  logic [QW-1:0]     q_cnt_r;
  logic [7:0]        sh_r;
  logic              rd_r, samp_r, pend_r, scl_oe_r, sda_oe_r;
  logic              scl_s, sda_s;

  // Line inputs come from the pins, so they are synchronised first
  i2c3m_sync #(.WIDTH(2)) u_sync (
    .clock    (clock),
    .arst_n   (arst_n),
    .ce       (ce),
    .async_in ({scl_i, sda_i}),
    .sync_out ({scl_s, sda_s})
  );

  // AXI write channel handshakes; address and data taken in any order
  wire wr_fire = ce & aw_hold_r & w_hold_r & ~bvalid_r;
  assign s_axi_awready = ce & ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready  = ce & ~w_hold_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  wire wr_xfer  = wr_fire & (aw_addr_r == XFER_OFS);
  wire wr_stat  = wr_fire & (aw_addr_r == STAT_OFS);
  wire wr_irqen = wr_fire & (aw_addr_r == IRQEN_OFS);
  wire wr_map   = wr_xfer | wr_stat | wr_irqen;
  wire [31:0] wmask = {{BYTE_W{w_strb_r[3]}}, {BYTE_W{w_strb_r[2]}},
                       {BYTE_W{w_strb_r[1]}}, {BYTE_W{w_strb_r[0]}}};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bresp_r   <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read mux; unmapped words read zero with a slave error
  wire        err_w    = (|flags_r) | ovr_r; // [RL5]
  wire [31:0] xfer_rd  = {xfer_r[BYTE_TOP:FLAG_LO], err_w, busy_r}; // [RL20]
  wire [31:0] stat_rd  = 32'({rate_r, 1'b0, flags_r, err_w, busy_r});
  wire        rd_xfer  = s_axi_araddr == XFER_OFS;
  wire        rd_stat  = s_axi_araddr == STAT_OFS;
  wire        rd_irqen = s_axi_araddr == IRQEN_OFS;
  wire [31:0] rd_mux   = rd_xfer ? xfer_rd : rd_stat ? stat_rd :
                         rd_irqen ? 32'(irq_en_r) : 32'h0000_0000;
  assign s_axi_arready = ce & ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_mux;
        rresp_r  <= (rd_xfer | rd_stat | rd_irqen) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Current slot view: slot 0 is the upper byte
  wire [4:0]   byte_lsb  = 5'(BYTE_TOP + 1 - BYTE_W * (slot_r + 1));
  wire [2:0]   attr_lsb  = 3'(ATTR_TOP + 1 - ATTR_W * (slot_r + 1));
  wire [7:0]   cur_byte  = xfer_r[byte_lsb +: BYTE_W]; // [RL7]
  i2c3m_attr_t cur_attr;
  assign cur_attr = i2c3m_attr_t'(xfer_r[attr_lsb +: ATTR_W]); // [RL8]

  // Address bytes always transmit; data direction follows the last R/W bit
  wire tx_w      = (cur_attr == A_START) | ~rd_r; // [RL9]
  wire load_low  = tx_w & ~cur_byte[BYTE_W-1];
  wire ack_send  = cur_attr != A_STOP; // [RL12]
  wire want_low  = (bit_r == LAST_DATA) ? (~tx_w & ack_send)
                                        : (tx_w & ~sh_r[BYTE_W-1]); // [RL10]

  // Quarter-bit timer; a held-low SCL restarts the rise quarter
  wire [12:0]   div_w   = i2c3m_rate_div(rate_r); // [RL1] [RL23]
  wire [QW-1:0] q_len   = QW'(div_w / 13'(QUARTERS)) - QW'(1);
  wire          active  = (st_r == ST_START) | (st_r == ST_BIT) |
                          (st_r == ST_STOP);
  wire          stretch = (ph_r == PH_RISE) & ~scl_s; // [RL2]
  wire          tick    = active & ~stretch & (q_cnt_r == '0);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q_cnt_r <= '0;
    end else if (ce) begin
      q_cnt_r <= (!active || tick || stretch) ? q_len : q_cnt_r - QW'(1);
    end
  end

  // Bus events; SDA is judged only while SCL is high
  wire in_bit   = st_r == ST_BIT;
  wire at_samp  = tick & (ph_r == PH_RISE);
  wire ack_samp = in_bit & at_samp & (bit_r == ACK_BIT);
  wire [NFLAG-1:0] ev_w;
  assign ev_w[F_AL] = at_samp & ~sda_s & ((st_r == ST_START) |
                      (in_bit & tx_w & (bit_r != ACK_BIT) & ~sda_oe_r)); // [RL22]
  assign ev_w[F_SP] = (in_bit & (ph_r == PH_HIGH) & (sda_s != samp_r)) |
                      ((st_r == ST_STOP) & tick & (ph_r == PH_HIGH) &
                       ~sda_s); // [RL24]
  assign ev_w[F_AP] = ack_samp & tx_w & sda_s & (cur_attr == A_START);
  assign ev_w[F_DT] = ack_samp & tx_w & sda_s & (cur_attr == A_TRANSFER_AND_CONTINUE);
  assign ev_w[F_DR] = ack_samp & ~tx_w & sda_s & ack_send; // [RL4]
  wire fatal_w  = ev_w[F_AL] | ev_w[F_SP];
  wire nack_w   = ev_w[F_AP] | ev_w[F_DT] | ev_w[F_DR];
  wire ack_done = in_bit & tick & (ph_r == PH_FALL) & (bit_r == ACK_BIT);
  wire store_w  = ack_done & ~tx_w; // [RL13]
  wire go_end   = fatal_w | ((st_r == ST_SLOT) & (slot_r == SLOT_DONE)) |
                  ((st_r == ST_STOP) & tick & (ph_r == PH_FALL) & pend_r);
  wire start_ok = wr_xfer & ~busy_r & ~err_w; // [RL6]
  wire abort_w  = wr_stat & w_strb_r[0] & w_data_r[ABORT_BIT];

  // Flag, overrun and busy next values; hardware set wins over clear
  wire lane0 = wr_stat & w_strb_r[0];
  wire [NFLAG-1:0] flags_nxt = (lane0 ? w_data_r[FLAG_HI:FLAG_LO] : flags_r)
                               | ev_w; // [RL4]
  wire ovr_nxt = (lane0 ? 1'b0 : ovr_r) | (wr_xfer & busy_r); // [RL16]
  wire err_nxt = (|flags_nxt) | ovr_nxt; // [RL17]
  wire busy_nxt = abort_w ? 1'b0 :                               // [RL3]
                  start_ok ? 1'b1 :                              // [RL14]
                  ((go_end | ((st_r == ST_END) & lane0)) & ~err_nxt)
                    ? 1'b0 : busy_r;                             // [RL18]

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_r  <= '0;
      ovr_r    <= 1'b0;
      busy_r   <= 1'b0;
      rate_r   <= RATE_RST;
      irq_en_r <= 1'b0;
      irq_r    <= 1'b0;
    end else if (ce) begin
      flags_r <= flags_nxt;
      ovr_r   <= ovr_nxt;
      busy_r  <= busy_nxt;
      irq_r   <= go_end & irq_en_r; // [RL15]
      if (wr_stat && w_strb_r[1]) rate_r <= w_data_r[RATE_HI:RATE_LO];
      if (wr_irqen && w_strb_r[0]) irq_en_r <= w_data_r[0];
    end
  end

  // Transfer word: software loads it when idle, the engine stores reads
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      xfer_r <= XFER_RST;
    end else if (ce) begin
      if (wr_xfer && !busy_r) begin
        xfer_r <= (xfer_r & ~(wmask & XFER_WMASK)) |
                  (w_data_r & wmask & XFER_WMASK);
      end else if (store_w) begin
        xfer_r[byte_lsb +: BYTE_W] <= sh_r; // [RL13]
      end
    end
  end

  // Byte engine; each tick ends one quarter of a bit or condition
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r     <= ST_IDLE;
      slot_r   <= SLOT_FIRST;
      ph_r     <= PH_SETUP;
      bit_r    <= '0;
      sh_r     <= '0;
      rd_r     <= 1'b0;
      samp_r   <= 1'b1;
      pend_r   <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (ce) begin
      if (abort_w) begin
        st_r     <= ST_IDLE; // [RL3]
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else if (go_end) begin
        st_r     <= ST_END; // [RL22]
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else begin
        case (st_r)
          // A start may land in the last cycle spent in the end state, once busy is low
          ST_IDLE, ST_END: begin
            if (start_ok) begin
              st_r   <= ST_SLOT; // [RL21]
              slot_r <= SLOT_FIRST;
              pend_r <= 1'b0;
            end else if (!busy_r) begin
              st_r <= ST_IDLE; // [RL18]
            end
          end
          ST_SLOT: begin
            if (cur_attr == A_NOP) begin
              slot_r <= slot_r + 2'h1; // [RL8] [RL21]
            end else if (cur_attr == A_START) begin
              st_r     <= ST_START; // [RL9]
              ph_r     <= PH_SETUP;
              sda_oe_r <= 1'b0;
            end else begin
              st_r     <= ST_BIT;
              ph_r     <= PH_SETUP;
              bit_r    <= '0;
              sh_r     <= cur_byte;
              sda_oe_r <= load_low;
            end
          end
          ST_START: begin
            if (tick) begin
              ph_r <= ph_r + 2'h1;
              case (ph_r)
                PH_SETUP: scl_oe_r <= 1'b0;
                PH_RISE:  sda_oe_r <= 1'b1; // [RL9]
                PH_HIGH:  scl_oe_r <= 1'b1;
                default: begin
                  st_r     <= ST_BIT;
                  bit_r    <= '0;
                  sh_r     <= cur_byte;
                  rd_r     <= cur_byte[0];
                  sda_oe_r <= load_low;
                end
              endcase
            end
          end
          ST_BIT: begin
            if (tick) begin
              ph_r <= ph_r + 2'h1;
              case (ph_r)
                PH_SETUP: scl_oe_r <= 1'b0;
                PH_RISE: begin
                  samp_r <= sda_s; // [RL24]
                  if (bit_r != ACK_BIT) sh_r <= {sh_r[6:0], sda_s};
                  if (nack_w) pend_r <= 1'b1;
                end
                PH_HIGH: scl_oe_r <= 1'b1;
                default: begin
                  if (bit_r != ACK_BIT) begin
                    bit_r    <= bit_r + 4'h1;
                    sda_oe_r <= want_low; // [RL10] [RL12]
                  end else if (pend_r || cur_attr == A_STOP) begin
                    st_r     <= ST_STOP; // [RL11]
                    sda_oe_r <= 1'b1;
                  end else begin
                    st_r     <= ST_SLOT; // [RL10]
                    slot_r   <= slot_r + 2'h1;
                    sda_oe_r <= 1'b0;
                  end
                end
              endcase
            end
          end
          ST_STOP: begin
            if (tick) begin
              ph_r <= ph_r + 2'h1;
              case (ph_r)
                PH_SETUP: scl_oe_r <= 1'b0;
                PH_RISE:  sda_oe_r <= 1'b0; // [RL11]
                PH_HIGH:  ;
                default: begin
                  st_r   <= ST_SLOT;
                  slot_r <= slot_r + 2'h1;
                end
              endcase
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Open-drain drive: the pins only ever pull low
  assign scl_o     = 1'b0; // [RL24]
  assign sda_o     = 1'b0;
  assign scl_oe    = scl_oe_r;
  assign sda_oe    = sda_oe_r;
  assign cycle_irq = irq_r;

  // Checks on the engine and the register side
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_ack_end_stop;
    ce && ack_done && cur_attr == A_STOP;
  endsequence
  sequence s_stretched;
    ce && in_bit && ph_r == PH_RISE && !scl_s;
  endsequence

  a_busy_on_start: assert property ( // [RL14]
    start_ok |=> busy_r && st_r == ST_SLOT && slot_r == SLOT_FIRST)
    else $error("busy not raised by transfer start");
  a_abort_clear: assert property ( // [RL3]
    ce && abort_w |=> !busy_r && st_r == ST_IDLE && !scl_oe && !sda_oe)
    else $error("abort did not end the operation");
  a_busy_write_err: assert property ( // [RL16]
    ce && wr_xfer && busy_r |=> err_w && $stable(xfer_r[BYTE_TOP:FLAG_LO]))
    else $error("write while busy not flagged");
  a_err_keeps_busy: assert property ( // [RL18]
    ce && go_end && err_nxt && !abort_w |=> busy_r && st_r == ST_END)
    else $error("busy dropped despite error");
  a_err_sticky: assert property ( // [RL5]
    $fell(err_w) |-> $past(lane0))
    else $error("summary error cleared without a status write");
  a_stretch_hold: assert property ( // [RL2]
    s_stretched |=> ph_r == PH_RISE && scl_oe == 1'b0)
    else $error("bit advanced while SCL held low");
  a_stop_follows: assert property ( // [RL11]
    s_ack_end_stop |=> st_r == ST_STOP && sda_oe ##1 scl_oe)
    else $error("stop byte not followed by stop condition");
  a_nack_last_rd: assert property ( // [RL12]
    in_bit && bit_r == ACK_BIT && !tx_w && cur_attr == A_STOP |-> !sda_oe)
    else $error("last read byte acknowledged");
  a_irq_at_end: assert property ( // [RL15]
    ce && go_end && irq_en_r |=> cycle_irq ##1 !cycle_irq)
    else $error("cycle end interrupt missing");
  a_store_read: assert property ( // [RL13]
    ce && store_w |=> xfer_r[$past(byte_lsb) +: BYTE_W] == $past(sh_r))
    else $error("received byte not stored in its slot");
  a_clean_run: assert property ( // [RL17]
    ce && go_end && !err_nxt && !abort_w |=> !err_w && !busy_r)
    else $error("clean run left error or busy");
endmodule

// ### bench/i2c3m_slave.sv
// Behavioural I2C slave: address match, write capture, read, stretching
`timescale 1ns/1ps
module i2c3m_slave #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] BASE = 8'hC4
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic [31:0] stre,
  output logic      scl_low,
  output logic      sda_low
);
  logic [7:0] sh, tx;
  logic [7:0] mem [0:15];
  logic       ap, rd, fr, ak;
  int         bc, wp;
  initial begin
    scl_low = 0; sda_low = 0; bc = 0; wp = 0;
    ap = 0; rd = 0; fr = 0; ak = 1;
  end
  // Start opens a frame, stop closes it
  always @(negedge sda) if (scl) begin
    bc = 0; ap = 1; rd = 0; fr = 1;
  end
  always @(posedge sda) if (scl) begin
    ap = 0; rd = 0; fr = 0;
  end
  // Shift data in, then the acknowledge bit
  always @(posedge scl) begin
    if (bc < 8) sh = {sh[6:0], sda};
    else ak = sda;
    bc++;
  end
  // Drive only while SCL low; release means the pull-up wins
  always @(negedge scl) begin
    if (bc == 8) sda_low = fr && !rd && (!ap || sh[7:1] == ADDR);
    else if (bc == 9) begin
      bc = 0;
      if (ap) begin
        fr = sh[7:1] == ADDR; rd = fr && sh[0]; tx = BASE;
      end
      else if (rd) tx = tx + 8'h01;
      else if (fr) begin
        mem[wp] = sh; wp++;
      end
      ap = 0;
      sda_low = rd && !ak && !tx[7];
      // Hold SCL low after each byte to slow the master
      if (stre > 0) begin
        scl_low = 1; #(stre); scl_low = 0;
      end
    end
    else sda_low = rd && !tx[7-bc];
  end
endmodule

// ### bench/i2c_three_byte_master_tb.sv
// Self-checking bench for the three-byte I2C master
`timescale 1ns/1ps
module i2c_three_byte_master_tb;
  import i2c3m_pkg::*;
  logic        clock = 0, arst_n = 0, awv = 0, wv = 0, arv = 0;
  logic [7:0]  awa = 0, ara = 0, d1, d2;
  logic [31:0] wd = 0, v, ex;
  logic [1:0]  r;
  wire         awr, wrd, bv, arr, rv, soe, doe, irq, scl, sda, sl, dl;
  wire  [1:0]  brs, rrs;
  wire  [31:0] rdt;
  int          error_cnt = 0, tests_run = 0, ic = 0, stre = 0, n, m, k;
  realtime     tl = 0, tmin = 0;
  // Open-drain lines with pull-ups
  assign scl = !soe && !sl;
  assign sda = !doe && !dl;
  always #50 clock = !clock;
  always @(posedge clock) if (irq === 1'b1) ic++;
  // Shortest SCL rise-to-rise spacing
  always @(posedge scl) begin
    if ($realtime - tl < tmin) tmin = $realtime - tl;
    tl = $realtime;
  end
  i2c3m_core uut (.clock(clock), .arst_n(arst_n), .ce(1'b1),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_bresp(brs), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .s_axi_rdata(rdt), .s_axi_rresp(rrs), .scl_i(scl), .scl_o(),
    .scl_oe(soe), .sda_i(sda), .sda_o(), .sda_oe(doe), .cycle_irq(irq));
  i2c3m_slave s (.scl(scl), .sda(sda), .stre(stre), .scl_low(sl),
    .sda_low(dl));
  // Write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 0; tw = 0;
    awa <= a; wd <= d; awv <= 1; wv <= 1;
    do begin
      @(posedge clock);
      ta |= awr; tw |= wrd;
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end while (!(ta && tw));
    do @(posedge clock); while (bv !== 1'b1);
    r = brs;
  endtask
  task automatic rd(input logic [7:0] a);
    ara <= a; arv <= 1;
    do @(posedge clock); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clock); while (rv !== 1'b1);
    v = rdt; r = rrs;
  endtask
  task automatic chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t got %h want %h", $time, g, e);
    end
  endtask
  // Poll until idle or halted on an error
  task automatic idle;
    do rd(XFER_OFS); while (v[0] === 1'b1 && v[1] !== 1'b1);
  endtask
  // Clearing may take more than one write after a fault
  task automatic clr;
    do begin
      wr(STAT_OFS, 32'h300); rd(STAT_OFS);
    end while (v[1:0] !== 2'b00);
  endtask
  function automatic logic [31:0] xw(input logic [7:0] b0, b1, b2,
    input i2c3m_attr_t a0, a1, a2);
    return {b0, b1, b2, a0, a1, a2, 2'b00};
  endfunction
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #4000000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    void'($urandom(4));
    repeat (4) @(posedge clock);
    arst_n <= 1;
    @(posedge clock);
    rd(XFER_OFS); chk(v, XFER_RST); chk(r, RESP_OKAY);
    rd(STAT_OFS); chk(v, 0);
    rd(8'h00); chk(v, 0); chk(r, RESP_SLVERR);
    wr(IRQEN_OFS, 1); chk(r, RESP_OKAY);
    wr(8'h04, 32'hFFFF_FFFF); chk(r, RESP_SLVERR);
    $display("Test registers done");
    // Writes at two rates; second run skips the middle slot
    for (k = 0; k < 2; k++) begin
      wr(STAT_OFS, k ? 32'h300 : 32'h200);
      d1 = $urandom; d2 = $urandom; n = s.wp; m = ic; tmin = 1e9;
      ex = xw(8'h54, d1, d2, A_START, k ? A_NOP : A_TRANSFER_AND_CONTINUE, A_STOP);
      wr(XFER_OFS, ex);
      idle;
      chk(v, ex);
      chk(s.wp - n, 2 - k);
      chk(s.mem[s.wp-1], d2);
      if (k == 0) chk(s.mem[n], d1);
      chk(ic - m, 1);
      m = k ? 60 : 80;
      chk(tmin >= 100.0 * m && tmin <= 100.0 * (m + 6), 1);
    end
    $display("Test write done");
    stre <= 3000;
    wr(XFER_OFS, xw(8'h55, d1, d2, A_START, A_TRANSFER_AND_CONTINUE, A_STOP));
    idle;
    chk(v, xw(8'h55, 8'hC4, 8'hC5, A_START, A_TRANSFER_AND_CONTINUE, A_STOP));
    chk(s.ak, 1);
    stre <= 0;
    $display("Test read done");
    ex = xw(8'h22, d1, d2, A_START, A_TRANSFER_AND_CONTINUE, A_STOP);
    wr(XFER_OFS, ex);
    wr(XFER_OFS, 0);
    do rd(STAT_OFS); while (v[5] !== 1'b1);
    chk(v, 32'h323);
    rd(XFER_OFS); chk(v, ex | 32'h3);
    clr; chk(v, 32'h300);
    $display("Test error done");
    wr(XFER_OFS, xw(8'h54, d1, d2, A_START, A_TRANSFER_AND_CONTINUE, A_STOP));
    wr(STAT_OFS, 32'h380);
    rd(STAT_OFS); chk(v[0], 0);
    clr; chk(v, 32'h300);
    $display("Test abort done");
    report_and_stop;
  end
endmodule
